// *** verilog/uart_reg_select.sv ***
// register selection, receive fifo and receive interrupt for one uart channel
//
// How it works
// - divisor bytes at 000/001 read and write only while line format bit 7 set and line format is not BF.
// - extended mask, queue and modem bits stay zero unless function bit 4 set.
// - mask register gates rx ready, tx empty, line and modem sources into source register.
// - fifo on and rx enabled: interrupt when level reaches trigger, clears below it.
// - source bits 3:0 read 0100 at trigger; status and interrupt clear together below trigger.
// - data ready bit sets when a character enters the fifo, clears when fifo empties.
`timescale 1ns/100ps
`default_nettype none
module uart_reg_select
    import uart_regs_pkg::*;
#(
    parameter int  DEPTH     = FIFO_DEPTH,
    parameter logic [7:0] REV_CODE  = 8'h01, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5A  // arbitrary value
) (
    input  wire logic       CLK_SYS,
    input  wire logic       ARST_N,
    input  wire logic [2:0] ADDR,
    input  wire logic       WR,
    input  wire logic       RD,
    input  wire logic [7:0] WDATA,
    output logic      [7:0] RDATA,
    input  wire logic       RX_CHAR_VALID,
    input  wire logic [7:0] RX_CHAR,
    input  wire logic       TX_EMPTY,
    input  wire logic       LINE_ERR,
    input  wire logic       MODEM_CHG,
    output logic            INT_OUT,
    output logic            RX_READY,
    output logic      [7:0] DIVISOR_LOW,
    output logic      [7:0] DIVISOR_HIGH,
    output logic      [7:0] MODEM_OUT
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = (AW + 1 > 8) ? AW + 1 : 8;

    logic [7:0]    line_format_reg;
    logic [7:0]    enhanced_function;
    logic [7:0]    irq_mask_reg;
    logic [7:0]    queue_control_reg;
    logic [7:0]    modem_output_reg;
    logic [7:0]    feature_control;
    logic [7:0]    fifo_trigger_level;
    logic [7:0]    resume_char_one;
    logic [7:0]    resume_char_two;
    logic [7:0]    pause_char_one;
    logic [7:0]    pause_char_two;
    logic [7:0]    scratch;
    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   level;
    logic          enh_bank;
    logic          div_bank;
    logic          enh_on;
    logic          fifo_on;
    logic          rx_hit;
    logic          rx_irq;
    logic          do_pop;
    logic          do_push;
    logic [3:0]    next_src;
    logic [7:0]    next_rdata;
    logic [7:0]    line_state_reg;

    assign enh_bank = (line_format_reg == BANK_ENH_CODE);
    assign div_bank = line_format_reg[LCR_DIV_BIT] && !enh_bank;
    assign enh_on   = enhanced_function[EFR_ENH_BIT];
    assign fifo_on  = queue_control_reg[FCR_EN_BIT];

    function automatic logic [7:0] gate_ext(input logic [7:0] v, input logic [7:0] base, input logic en);
        gate_ext = en ? v : (v & base);
    endfunction

    // host writes
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            line_format_reg    <= RESET_LCR;
            enhanced_function  <= RESET_BYTE;
            irq_mask_reg       <= RESET_BYTE;
            queue_control_reg  <= RESET_BYTE;
            modem_output_reg   <= RESET_BYTE;
            feature_control    <= RESET_BYTE;
            fifo_trigger_level <= RESET_TRIG;
            DIVISOR_LOW        <= RESET_BYTE;
            DIVISOR_HIGH       <= RESET_BYTE;
            resume_char_one    <= RESET_BYTE;
            resume_char_two    <= RESET_BYTE;
            pause_char_one     <= RESET_BYTE;
            pause_char_two     <= RESET_BYTE;
            scratch            <= RESET_BYTE;
        end else if (WR) begin
            if (ADDR == ADDR_3) begin
                line_format_reg <= WDATA;
            end else if (enh_bank) begin
                case (ADDR)
                    ADDR_0:  fifo_trigger_level <= WDATA;
                    ADDR_1:  feature_control    <= WDATA;
                    ADDR_2:  enhanced_function  <= WDATA;
                    ADDR_4:  resume_char_one    <= WDATA;
                    ADDR_5:  resume_char_two    <= WDATA;
                    ADDR_6:  pause_char_one     <= WDATA;
                    ADDR_7:  pause_char_two     <= WDATA;
                    default: ;
                endcase
            end else begin
                case (ADDR)
                    ADDR_0:  if (div_bank) DIVISOR_LOW <= WDATA;
                    ADDR_1:  if (div_bank) DIVISOR_HIGH <= WDATA;
                             else irq_mask_reg <= gate_ext(WDATA, IER_BASE_MASK, enh_on);
                    ADDR_2:  queue_control_reg <= gate_ext(WDATA, FCR_BASE_MASK, enh_on);
                    ADDR_4:  modem_output_reg <= gate_ext(WDATA, MCR_BASE_MASK, enh_on);
                    ADDR_7:  scratch <= WDATA;
                    default: ;
                endcase
            end
        end
    end

    assign do_pop  = RD && ADDR == ADDR_0 && !div_bank && !enh_bank && level != '0;
    assign do_push = RX_CHAR_VALID && level != (AW+1)'(DEPTH);

    // receive fifo
    always_ff @(posedge CLK_SYS) begin
        if (do_push) mem[wptr] <= RX_CHAR;
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            wptr  <= '0;
            rptr  <= '0;
            level <= '0;
        end else begin
            if (do_push) wptr <= wptr + 1'b1;
            if (do_pop) rptr <= rptr + 1'b1;
            level <= level + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // trigger comparison; non-fifo mode triggers on one character
    assign rx_hit = fifo_on ? (CW'(level) >= CW'(fifo_trigger_level) && level != '0)
                            : (level != '0);
    assign rx_irq = rx_hit && irq_mask_reg[0];

    always_comb begin
        next_src = ISR_NONE;
        if (LINE_ERR && irq_mask_reg[2]) next_src = ISR_LINE;
        else if (rx_irq) next_src = ISR_RXRDY;
        else if (TX_EMPTY && irq_mask_reg[1]) next_src = ISR_TXRDY;
        else if (MODEM_CHG && irq_mask_reg[3]) next_src = ISR_MODEM;
    end

    assign line_state_reg = {1'b0, TX_EMPTY, TX_EMPTY, 4'h0, level != '0};

    always_comb begin
        next_rdata = RESET_BYTE;
        if (enh_bank) begin
            case (ADDR)
                ADDR_0:  next_rdata = 8'(level);
                ADDR_1:  next_rdata = feature_control;
                ADDR_2:  next_rdata = enhanced_function;
                ADDR_3:  next_rdata = line_format_reg;
                ADDR_4:  next_rdata = resume_char_one;
                ADDR_5:  next_rdata = resume_char_two;
                ADDR_6:  next_rdata = pause_char_one;
                ADDR_7:  next_rdata = pause_char_two;
                default: next_rdata = RESET_BYTE;
            endcase
        end else begin
            case (ADDR)
                ADDR_0:  next_rdata = div_bank ? DIVISOR_LOW : ((level != '0) ? mem[rptr] : RESET_BYTE);
                ADDR_1:  next_rdata = div_bank ? DIVISOR_HIGH : gate_ext(irq_mask_reg, IER_BASE_MASK, enh_on);
                ADDR_2:  next_rdata = {{2{fifo_on}}, 2'b00, next_src};
                ADDR_3:  next_rdata = line_format_reg;
                ADDR_4:  next_rdata = modem_output_reg;
                ADDR_5:  next_rdata = line_state_reg;
                ADDR_7:  next_rdata = scratch;
                default: next_rdata = RESET_BYTE;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA     <= RESET_BYTE;
            INT_OUT   <= 1'b0;
            RX_READY  <= 1'b0;
            MODEM_OUT <= RESET_BYTE;
        end else begin
            RDATA     <= next_rdata;
            INT_OUT   <= next_src != ISR_NONE;
            RX_READY  <= level != '0 || do_push;
            MODEM_OUT <= gate_ext(modem_output_reg, MCR_BASE_MASK, enh_on);
        end
    end

    // checks
    property p_div_write;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (WR && ADDR == ADDR_0 && !div_bank) |=> $stable(DIVISOR_LOW);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divisor low written outside divisor bank");

    property p_ext_gate;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (!enh_on && !enh_bank && !div_bank && ADDR == ADDR_1) |=> RDATA[7:4] == 4'h0;
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("extended mask bits set while disabled");

    property p_mask;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (irq_mask_reg[3:0] == 4'h0) |=> !INT_OUT;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt with all sources masked");

    property p_trig_rise;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (fifo_on && irq_mask_reg[0] && level != '0 && 8'(level) >= fifo_trigger_level) |=> INT_OUT;
    endproperty
    a_trig_rise: assert property (p_trig_rise) else $error("no interrupt at trigger level");

    property p_trig_status;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (next_src == ISR_RXRDY) |-> rx_hit && irq_mask_reg[0];
    endproperty
    a_trig_status: assert property (p_trig_status) else $error("rx status without trigger");

    property p_ready_set;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        do_push |=> RX_READY ##1 RX_READY;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("data ready not set after push");

    property p_ready_clr;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (level == '0 && !do_push) |=> !RX_READY;
    endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("data ready with empty fifo");

    property p_bank_trig;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (WR && enh_bank && ADDR == ADDR_0) |=> fifo_trigger_level == $past(WDATA);
    endproperty
    a_bank_trig: assert property (p_bank_trig) else $error("trigger not loaded in enhanced bank");

    property p_div_high_write;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (WR && ADDR == ADDR_1 && !div_bank) |=> $stable(DIVISOR_HIGH);
    endproperty
    a_div_high_write: assert property (p_div_high_write) else $error("divisor high written outside divisor bank");

    property p_div_low_load;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (WR && ADDR == ADDR_0 && div_bank) |=> DIVISOR_LOW == $past(WDATA);
    endproperty
    a_div_low_load: assert property (p_div_low_load) else $error("divisor low not loaded in divisor bank");

    property p_modem_gate;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !enh_on |=> (MODEM_OUT & ~MCR_BASE_MASK) == 8'h00;
    endproperty
    a_modem_gate: assert property (p_modem_gate) else $error("extended modem bits active while disabled");

    property p_queue_gate;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (WR && ADDR == ADDR_2 && !enh_bank && !enh_on) |=> queue_control_reg[5:4] == 2'b00;
    endproperty
    a_queue_gate: assert property (p_queue_gate) else $error("extended queue bits written while disabled");

    property p_rx_masked;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !irq_mask_reg[0] |-> next_src != ISR_RXRDY;
    endproperty
    a_rx_masked: assert property (p_rx_masked) else $error("masked rx source reported");

    property p_int_src;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (next_src != ISR_NONE) |=> INT_OUT;
    endproperty
    a_int_src: assert property (p_int_src) else $error("pending source without interrupt");

    property p_trig_fall;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (fifo_on && 8'(level) < fifo_trigger_level && !LINE_ERR && !TX_EMPTY && !MODEM_CHG) |=> !INT_OUT;
    endproperty
    a_trig_fall: assert property (p_trig_fall) else $error("interrupt below trigger level");

    property p_status_clr;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (!enh_bank && ADDR == ADDR_2 && !rx_hit) |=> RDATA[3:0] != ISR_RXRDY;
    endproperty
    a_status_clr: assert property (p_status_clr) else $error("rx status shown below trigger");

    property p_ready_hold;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (level != '0) |=> RX_READY;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("data ready dropped with data in fifo");

    property p_level_read;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (enh_bank && ADDR == ADDR_0) |=> RDATA == 8'($past(level));
    endproperty
    a_level_read: assert property (p_level_read) else $error("enhanced bank read not fifo level");
endmodule // uart_reg_select
`default_nettype wire

// *** verilog/uart_regs_pkg.sv ***
// constants for the uart register selection and receive interrupt block
package uart_regs_pkg;
    localparam logic [2:0] ADDR_0        = 3'h0;
    localparam logic [2:0] ADDR_1        = 3'h1;
    localparam logic [2:0] ADDR_2        = 3'h2;
    localparam logic [2:0] ADDR_3        = 3'h3;
    localparam logic [2:0] ADDR_4        = 3'h4;
    localparam logic [2:0] ADDR_5        = 3'h5;
    localparam logic [2:0] ADDR_6        = 3'h6;
    localparam logic [2:0] ADDR_7        = 3'h7;
    localparam logic [7:0] BANK_ENH_CODE = 8'hBF;
    localparam int         LCR_DIV_BIT   = 7;
    localparam int         EFR_ENH_BIT   = 4;
    localparam int         FCR_EN_BIT    = 0;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [7:0] RESET_LCR     = 8'h03;
    localparam logic [7:0] RESET_TRIG    = 8'h01;
    localparam logic [7:0] IER_BASE_MASK = 8'h0F;
    localparam logic [7:0] FCR_BASE_MASK = 8'hCF;
    localparam logic [7:0] MCR_BASE_MASK = 8'h1F;
    localparam logic [3:0] ISR_NONE      = 4'h1;
    localparam logic [3:0] ISR_LINE      = 4'h6;
    localparam logic [3:0] ISR_RXRDY     = 4'h4;
    localparam logic [3:0] ISR_TXRDY     = 4'h2;
    localparam logic [3:0] ISR_MODEM     = 4'h0;
    localparam int         FIFO_DEPTH    = 64;
endpackage

// *** sim/rx_path_model.sv ***
// behavioural receive path delivering characters into the block
`timescale 1ns/100ps
`default_nettype none
module rx_path_model (
    input  wire logic       clk_sys,
    output logic            char_valid,
    output logic      [7:0] char_byte
);
    initial begin
        char_valid = 1'b0;
        char_byte  = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        char_valid = 1'b1;
        char_byte  = b;
        @(negedge clk_sys);
        char_valid = 1'b0;
        char_byte  = ~b;
    endtask
endmodule // rx_path_model
`default_nettype wire

// *** sim/tb_uart_register_map_rx_interrupt.sv ***
// self-checking bench for the register selection block
`timescale 1ns/100ps
`default_nettype none
module tb_uart_register_map_rx_interrupt;
    import uart_regs_pkg::*;
    logic       clk_sys = 1'b0;
    logic       arst_n  = 1'b0;
    logic [2:0] addr    = ADDR_0;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] wdata   = 8'h00;
    logic [2:0] src     = 3'h0;
    logic [7:0] rdata, div_low, div_high, modem_out, rx_char, v, d0, d1;
    logic       rx_valid, int_out, rx_ready;
    logic [7:0] q[$];
    logic [7:0] mbit[3] = '{8'h04, 8'h02, 8'h08};
    logic [3:0] code[3] = '{ISR_LINE, ISR_TXRDY, ISR_MODEM};
    int         mismatches = 0;
    int         checked    = 0;
    int         cycles     = 0;
    rx_path_model rxm (.clk_sys(clk_sys), .char_valid(rx_valid), .char_byte(rx_char));
    uart_reg_select uut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata),
        .RDATA(rdata), .RX_CHAR_VALID(rx_valid), .RX_CHAR(rx_char), .TX_EMPTY(src[1]), .LINE_ERR(src[0]),
        .MODEM_CHG(src[2]), .INT_OUT(int_out), .RX_READY(rx_ready), .DIVISOR_LOW(div_low),
        .DIVISOR_HIGH(div_high), .MODEM_OUT(modem_out));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] base, input int e);
        return (e != 0) ? d : (d & base);
    endfunction
    task automatic report_and_stop;
        $display("counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk_sys);
        wr    = 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        rd   = 1'b1;
        @(negedge clk_sys);
        rd   = 1'b0;
        d    = rdata;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        v = 8'($urandom(32'hb713_d6ba));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        wr_reg(ADDR_3, 8'h80);
        wr_reg(ADDR_0, d0);
        wr_reg(ADDR_1, d1);
        rd_reg(ADDR_0, v);
        chk(v, d0, "divisor low read");
        rd_reg(ADDR_1, v);
        chk(v, d1, "divisor high read");
        wr_reg(ADDR_3, RESET_LCR);
        wr_reg(ADDR_0, ~d0);
        wr_reg(ADDR_1, ~d1);
        chk(div_low, d0, "divisor low kept");
        chk(div_high, d1, "divisor high kept");
        $display("test divisor done");
        for (int e = 0; e < 2; e++) begin
            wr_reg(ADDR_3, BANK_ENH_CODE);
            wr_reg(ADDR_2, (e != 0) ? 8'h10 : 8'h00);
            wr_reg(ADDR_3, RESET_LCR);
            v = 8'($urandom);
            wr_reg(ADDR_1, v);
            wr_reg(ADDR_4, v);
            rd_reg(ADDR_1, d0);
            chk(d0, masked(v, IER_BASE_MASK, e), "mask bits");
            chk(modem_out, masked(v, MCR_BASE_MASK, e), "modem bits");
        end
        $display("test extended bits done");
        for (int k = 0; k < 3; k++) begin
            src = 3'h1 << k;
            wr_reg(ADDR_1, 8'h00);
            @(negedge clk_sys);
            chk({7'h00, int_out}, 8'h00, "masked source");
            wr_reg(ADDR_1, mbit[k]);
            rd_reg(ADDR_2, v);
            chk({7'h00, int_out}, 8'h01, "open source");
            chk({4'h0, v[3:0]}, {4'h0, code[k]}, "source code");
            src = 3'h0;
        end
        $display("test mask done");
        wr_reg(ADDR_3, BANK_ENH_CODE);
        wr_reg(ADDR_0, 8'h04);
        rd_reg(ADDR_0, v);
        chk(v, 8'h00, "empty level");
        wr_reg(ADDR_3, RESET_LCR);
        wr_reg(ADDR_2, 8'h01);
        wr_reg(ADDR_1, 8'h01);
        chk({7'h00, rx_ready}, 8'h00, "ready while empty");
        for (int i = 1; i <= 4; i++) begin
            v = 8'($urandom);
            q.push_back(v);
            rxm.send(v);
            repeat (2) @(negedge clk_sys);
            chk({7'h00, rx_ready}, 8'h01, "ready after push");
            chk({7'h00, int_out}, (i == 4) ? 8'h01 : 8'h00, "trigger interrupt");
        end
        rd_reg(ADDR_2, v);
        chk({v[7:6], 2'h0, v[3:0]}, {2'h3, 2'h0, ISR_RXRDY}, "trigger status");
        wr_reg(ADDR_3, BANK_ENH_CODE);
        rd_reg(ADDR_0, v);
        chk(v, 8'h04, "fifo level");
        wr_reg(ADDR_3, RESET_LCR);
        for (int i = 4; i > 0; i--) begin
            rd_reg(ADDR_0, v);
            chk(v, q.pop_front(), "fifo data");
            repeat (2) @(negedge clk_sys);
            rd_reg(ADDR_2, d0);
            chk({7'h00, int_out}, 8'h00, "below trigger");
            chk({4'h0, d0[3:0]}, {4'h0, ISR_NONE}, "status cleared");
            chk({7'h00, rx_ready}, (i > 1) ? 8'h01 : 8'h00, "ready until empty");
        end
        $display("test receive fifo done");
        wr_reg(ADDR_2, 8'h00);
        v = 8'($urandom);
        rxm.send(v);
        repeat (2) @(negedge clk_sys);
        chk({7'h00, int_out}, 8'h01, "single char interrupt");
        rd_reg(ADDR_2, d0);
        chk(d0, {4'h0, ISR_RXRDY}, "non-fifo status");
        rd_reg(ADDR_0, d1);
        chk(d1, v, "non-fifo data");
        repeat (2) @(negedge clk_sys);
        chk({7'h00, int_out}, 8'h00, "single char cleared");
        chk({7'h00, rx_ready}, 8'h00, "ready cleared");
        $display("test non-fifo mode done");
        report_and_stop();
    end
endmodule // tb_uart_register_map_rx_interrupt
`default_nettype wire
